// *** hdl/pin_mux_pkg.sv ***
// Package with the function codes, line positions and reset values of the quad pin mux.
package pin_mux_pkg;

  // Number of channels and lines per channel.
  localparam int NUM_CHAN  = 4;
  localparam int NUM_LINES = 8;
  // Channels that own a synchronous serial engine.
  localparam int NUM_ENGINE_CHAN = 2;

  // Function selected on a channel.
  typedef enum logic [1:0] {
    FUNC_SERIAL   = 2'b00,
    FUNC_BITBANG  = 2'b01,
    FUNC_ENGINE   = 2'b10
  } func_e;

  // Bit-bang variant.
  typedef enum logic {
    BB_ASYNC = 1'b0,
    BB_SYNC  = 1'b1
  } bb_variant_e;

  // Line positions shared by all functions.
  localparam int LINE_TX_CLK   = 0;
  localparam int LINE_RX_DOUT  = 1;
  localparam int LINE_RTS_DIN  = 2;
  localparam int LINE_CTS_SEL  = 3;
  localparam int LINE_DTR_GP0  = 4;
  localparam int LINE_DSR_GP1  = 5;
  localparam int LINE_DCD_GP2  = 6;
  localparam int LINE_RI_GP3   = 7;
  localparam int GP_LOW        = 4;
  localparam int GP_WIDTH      = 4;

  // Serial mode output enable pattern: lines 0, 2, 4 driven; line 7 by option.
  localparam logic [7:0] SERIAL_OE = 8'h15;
  localparam logic [7:0] LINE7_BIT = 8'h80;
  // Engine mode fixed drivers: clock, data out, select.
  localparam logic [3:0] ENGINE_LOW_OE = 4'hb;

  // Reset values.
  localparam logic [7:0] RESET_LINES = 8'hff;
  localparam logic [7:0] RESET_OE    = 8'h00;
  localparam logic [1:0] RESET_SYNC  = 2'h0;

endpackage

// *** hdl/chan_if.sv ***
// Interface carrying one channel's resolved line drive and sampled lines.
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  logic [7:0] line_out;  // Value to drive on each line.
  logic [7:0] line_oe;   // High where the line is driven.
  logic [7:0] line_in;   // Synchronised line levels.
  modport mux (output line_out, output line_oe, input line_in);
  modport pins (input line_out, input line_oe, output line_in);
endinterface
`default_nettype wire

// *** hdl/line_sync.sv ***
// Two-flop synchroniser for one channel's eight line inputs.
`timescale 1ns/1ps
`default_nettype none
module line_sync (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] raw_in,
  chan_if.pins            ch
);
  logic [7:0] stage1;       // First stage, read only by the second.
  logic [7:0] stage2;       // Second stage, safe to use.
  logic [7:0] next_stage1;
  logic [7:0] next_stage2;

  // Next values of the synchroniser stages; lines idle high.
  always_comb begin
    if (srst) begin
      next_stage1 = pin_mux_pkg::RESET_LINES;
      next_stage2 = pin_mux_pkg::RESET_LINES;
    end else begin
      next_stage1 = raw_in;
      next_stage2 = stage1;
    end
  end

  // Register the stages.
  always_ff @(posedge clk) begin
    stage1 <= next_stage1;
    stage2 <= next_stage2;
  end

  assign ch.line_in = stage2;
endmodule
`default_nettype wire

// *** hdl/quad_channel_pin_function_mux.sv ***
// Top module: four-channel pin function multiplexer with wake logic.
// Each channel owns eight lines. Their role follows the function that the last
// setup command latched. Drives and enables are registered, so a new function
// reaches the pins one edge after the command is taken, without a glitch between.
// Pin levels pass a two-flop synchroniser and the decoded inputs add one flop.
// Limitation: an engine code on channels C and D is reported as given but drives
// the serial pattern, so software must not read engine behaviour from it there.
// Wake is edge armed: a ring line held low sends one resume request and must be
// released before another can follow. This keeps a stuck line from flooding the host.
// Serial outputs that are not driven carry a high level, except line seven, which carries the drive enable,
// so a stray enable would show the idle level of an active-low line rather than an asserted one.
`timescale 1ns/1ps
`default_nettype none
module quad_channel_pin_function_mux (
  input  wire logic        clk,
  input  wire logic        srst,
  // Function select per channel, two bits each; engine codes ignored on C and D.
  input  wire logic [7:0]  func_sel,
  // Setup command strobe applying func_sel and bb_sync_sel.
  input  wire logic        setup_cmd,
  // Bit-bang variant per channel, high for synchronous.
  input  wire logic [3:0]  bb_sync_sel,
  // Line seven option per channel from config store, high for transmit enable.
  input  wire logic [3:0]  line7_txen_cfg,
  // Wake configuration and bus state.
  input  wire logic        remote_wake_en,
  input  wire logic        pull_down_en,
  input  wire logic        bus_suspended,
  // Serial engine side, four channels; tx and rts in eight-bit bundles, dtr and drive enable one bit each.
  input  wire logic [31:0] ser_tx,
  input  wire logic [31:0] ser_rts_n,
  input  wire logic [3:0]  ser_dtr_n,
  input  wire logic [3:0]  rs485_drive_enable,
  // Bit-bang data and direction per channel.
  input  wire logic [31:0] bb_data_out,
  input  wire logic [31:0] bb_dir,
  // Synchronous engine side for channels A and B.
  input  wire logic [1:0]  engine_clock_out,
  input  wire logic [1:0]  engine_data_out,
  input  wire logic [1:0]  engine_select_out,
  input  wire logic [7:0]  engine_gp_out,
  input  wire logic [7:0]  engine_gp_dir,
  // Pins of the four channels.
  input  wire logic [7:0]  chan_a_lines_in,
  input  wire logic [7:0]  chan_b_lines_in,
  input  wire logic [7:0]  chan_c_lines_in,
  input  wire logic [7:0]  chan_d_lines_in,
  output logic [7:0]       chan_a_lines_out,
  output logic [7:0]       chan_b_lines_out,
  output logic [7:0]       chan_c_lines_out,
  output logic [7:0]       chan_d_lines_out,
  output logic [7:0]       chan_a_lines_oe,
  output logic [7:0]       chan_b_lines_oe,
  output logic [7:0]       chan_c_lines_oe,
  output logic [7:0]       chan_d_lines_oe,
  // Sampled lines returned to the channel logic.
  output logic [31:0]      lines_sampled,
  // Decoded serial inputs per channel, active low as on the pins.
  output logic [3:0]       ser_rx,
  output logic [3:0]       ser_cts_n,
  output logic [3:0]       ser_dsr_n,
  output logic [3:0]       carrier_detect_n,
  output logic [3:0]       ring_indicator_n,
  // Engine serial data input for channels A and B.
  output logic [1:0]       engine_data_in,
  // Active function and variant per channel.
  output logic [7:0]       func_active,
  output logic [3:0]       bb_sync_active,
  // Resume request toward the host controller, one-cycle pulse.
  output logic             resume_req
);
  // Raw pins gathered into one vector for the generate loop.
  logic [31:0] pins_raw;
  logic [31:0] pins_out;
  logic [31:0] pins_oe;
  logic [31:0] pins_sync;

  // Channel A sits in the low byte, as on every other 32-bit bundle of this block.
  assign pins_raw = {chan_d_lines_in, chan_c_lines_in, chan_b_lines_in, chan_a_lines_in};

  // Latched function and variant selection, changed only by a setup command or reset.
  logic [7:0] func_q;
  logic [3:0] bbsync_q;
  logic [7:0] next_func;
  logic [3:0] next_bbsync;

  // Registered pin drives and decoded inputs.
  logic [31:0] out_q;     // Line values on the pins.
  logic [31:0] oe_q;      // Line enables on the pins.
  logic [31:0] next_out;  // Next line values.
  logic [31:0] next_oe;   // Next line enables.
  logic [3:0]  rx_q;      // Receive line per channel.
  logic [3:0]  cts_q;     // Clear-to-send, low active.
  logic [3:0]  dsr_q;     // Data-set-ready, low active.
  logic [3:0]  dcd_q;     // Carrier detect, low active.
  logic [3:0]  ri_q;      // Ring indicator, low active.
  logic [3:0]  next_rx;   // Next receive line.
  logic [3:0]  next_cts;  // Next clear-to-send.
  logic [3:0]  next_dsr;  // Next data-set-ready.
  logic [3:0]  next_dcd;  // Next carrier detect.
  logic [3:0]  next_ri;   // Next ring indicator.
  logic [1:0]  din_q;     // Engine data input of A and B.
  logic [1:0]  next_din;  // Next engine data input.

  // Wake edge detection on ring indicator.
  logic        wake_armed;
  logic        next_wake_armed;
  logic        resume_q;
  logic        next_resume;
  logic        ring_low_any;

  // Per-channel combinational drive and decode from the generate loop.
  logic [7:0]  chan_out [4];
  logic [7:0]  chan_oe  [4];

  // One pass of the loop per channel; the engine branch takes effect only where allowed.
  genvar g;
  generate
    for (g = 0; g < pin_mux_pkg::NUM_CHAN; g++) begin : gen_chan
      chan_if ch ();
      logic [1:0] fsel;
      logic       engine_ok;

      // Each channel's lines pass two flops before anything reads them.
      line_sync u_sync (
        .clk    (clk),
        .srst   (srst),
        .raw_in (pins_raw[8*g +: 8]),
        .ch     (ch.pins)
      );

      // Only the first two channels may run the engine; others fall back to serial.
      assign fsel      = func_q[2*g +: 2];
      assign engine_ok = (g < pin_mux_pkg::NUM_ENGINE_CHAN);

      // Drive pattern for the selected function, same line order in each.
      always_comb begin
        ch.line_out = pin_mux_pkg::RESET_LINES;
        ch.line_oe  = pin_mux_pkg::RESET_OE;
        case (fsel)
          pin_mux_pkg::FUNC_BITBANG: begin
            // All eight lines are data; direction per bit, for both variants.
            ch.line_out = bb_data_out[8*g +: 8];
            ch.line_oe  = bb_dir[8*g +: 8];
          end
          pin_mux_pkg::FUNC_ENGINE: begin
            if (engine_ok) begin
              // Clock, data out and select are fixed outputs of the engine.
              // General-purpose lines take their direction from the engine, bit by bit.
              ch.line_out[pin_mux_pkg::LINE_TX_CLK]  = engine_clock_out[g % 2];
              ch.line_out[pin_mux_pkg::LINE_RX_DOUT] = engine_data_out[g % 2];
              ch.line_out[pin_mux_pkg::LINE_CTS_SEL] = engine_select_out[g % 2];
              ch.line_out[pin_mux_pkg::GP_LOW +: pin_mux_pkg::GP_WIDTH] = engine_gp_out[4*(g%2) +: 4];
              // Data-in line stays undriven.
              ch.line_oe  = {engine_gp_dir[4*(g%2) +: 4], pin_mux_pkg::ENGINE_LOW_OE};
            end else begin
              // A stray engine code on C or D is treated as serial.
              ch.line_out = {rs485_drive_enable[g], 2'h3, ser_dtr_n[g], 1'h1, ser_rts_n[8*g], 1'h1, ser_tx[8*g]};
              ch.line_oe  = pin_mux_pkg::SERIAL_OE | (line7_txen_cfg[g] ? pin_mux_pkg::LINE7_BIT : 8'h00);
            end
          end
          default: begin
            // Serial: tx, rts, dtr driven; rx, cts, dsr, dcd sampled.
            // Bit order: line seven, two idle inputs, dtr, cts idle, rts, rx idle, tx.
            ch.line_out = {rs485_drive_enable[g], 2'h3, ser_dtr_n[g], 1'h1, ser_rts_n[8*g], 1'h1, ser_tx[8*g]};
            // Line seven drives only when transmit enable was configured.
            ch.line_oe  = pin_mux_pkg::SERIAL_OE | (line7_txen_cfg[g] ? pin_mux_pkg::LINE7_BIT : 8'h00);
          end
        endcase
      end

      assign chan_out[g] = ch.line_out;
      assign chan_oe[g]  = ch.line_oe;
      assign pins_sync[8*g +: 8] = ch.line_in;
    end
  endgenerate

  // Flatten per-channel drives.
  // Channel A lands in the low byte so the pin ports slice the same way.
  always_comb begin
    pins_out = {chan_out[3], chan_out[2], chan_out[1], chan_out[0]};
    pins_oe  = {chan_oe[3], chan_oe[2], chan_oe[1], chan_oe[0]};
  end

  // Next function state: the setup command loads new selections.
  // Between commands the selection holds, so pins never change function on their own.
  always_comb begin
    next_func   = func_q;
    next_bbsync = bbsync_q;
    if (srst) begin
      next_func   = {4{pin_mux_pkg::FUNC_SERIAL}};
      next_bbsync = {4{pin_mux_pkg::BB_ASYNC}};
    end else if (setup_cmd) begin
      next_func   = func_sel;
      next_bbsync = bb_sync_sel;
    end
  end

  // Register function state.
  // This flop is the only state behind the function and variant outputs.
  always_ff @(posedge clk) begin
    func_q   <= next_func;
    bbsync_q <= next_bbsync;
  end

  // Ring is counted only on channels whose line seven is an input in serial use.
  // A bit-bang or engine line seven is data, and a low level there is no ring.
  // Transmit enable lines are skipped too, since the block drives them itself.
  always_comb begin
    ring_low_any = 1'b0;
    for (int i = 0; i < pin_mux_pkg::NUM_CHAN; i++) begin
      if (func_q[2*i +: 2] != pin_mux_pkg::FUNC_BITBANG && !line7_txen_cfg[i]
          && !(func_q[2*i +: 2] == pin_mux_pkg::FUNC_ENGINE && i < pin_mux_pkg::NUM_ENGINE_CHAN)
          && !pins_sync[8*i + pin_mux_pkg::LINE_RI_GP3]) begin
        ring_low_any = 1'b1;
      end
    end
  end

  // Next decode and drive registers; outputs come straight from these flops.
  // The decode ignores the function, so the user must pick the outputs that apply.
  // Reset forces released lines and idle inputs, so nothing is driven at power-up.
  always_comb begin
    next_out = pins_out;
    next_oe  = pins_oe;
    next_din = {pins_sync[8 + pin_mux_pkg::LINE_RTS_DIN], pins_sync[pin_mux_pkg::LINE_RTS_DIN]};
    for (int i = 0; i < pin_mux_pkg::NUM_CHAN; i++) begin
      next_rx[i]  = pins_sync[8*i + pin_mux_pkg::LINE_RX_DOUT];
      next_cts[i] = pins_sync[8*i + pin_mux_pkg::LINE_CTS_SEL];
      next_dsr[i] = pins_sync[8*i + pin_mux_pkg::LINE_DSR_GP1];
      next_dcd[i] = pins_sync[8*i + pin_mux_pkg::LINE_DCD_GP2];
      // Ring reads high when line seven is transmit enable, so it never looks active.
      next_ri[i]  = pins_sync[8*i + pin_mux_pkg::LINE_RI_GP3] | line7_txen_cfg[i];
    end
    if (srst) begin
      next_out = {4{pin_mux_pkg::RESET_LINES}};
      next_oe  = {4{pin_mux_pkg::RESET_OE}};
      next_din = pin_mux_pkg::RESET_SYNC;
      next_rx  = 4'hf;
      next_cts = 4'hf;
      next_dsr = 4'hf;
      next_dcd = 4'hf;
      next_ri  = 4'hf;
    end
  end

  // Register drives and decodes.
  // Registering the drives costs one cycle but keeps the pins free of glitches.
  always_ff @(posedge clk) begin
    out_q <= next_out;
    oe_q  <= next_oe;
    din_q <= next_din;
    rx_q  <= next_rx;
    cts_q <= next_cts;
    dsr_q <= next_dsr;
    dcd_q <= next_dcd;
    ri_q  <= next_ri;
  end

  // Wake: one pulse per ring assertion; arming again needs ring released,
  // so a held ring line cannot flood the host with resume requests.
  always_comb begin
    next_wake_armed = wake_armed;
    next_resume     = 1'b0;
    if (srst) begin
      // Lines reset high, so arming at reset cannot see a false ring edge.
      next_wake_armed = 1'b1;
    end else if (!ring_low_any) begin
      // Ring released: the next low level may wake again.
      next_wake_armed = 1'b1;
    end else if (wake_armed) begin
      // First cycle of a ring: disarm whether or not a request is sent.
      next_wake_armed = 1'b0;
      // Pull-down blocks wake even if the wake condition is met.
      next_resume = remote_wake_en && bus_suspended && !pull_down_en;
    end
  end

  // Register wake state.
  // The resume request is a flop output and lasts exactly one cycle.
  always_ff @(posedge clk) begin
    wake_armed <= next_wake_armed;
    resume_q   <= next_resume;
  end

  // Pin drives, one byte per channel.
  assign chan_a_lines_out = out_q[7:0];
  assign chan_b_lines_out = out_q[15:8];
  assign chan_c_lines_out = out_q[23:16];
  assign chan_d_lines_out = out_q[31:24];
  // Pin enables, high where the line is driven.
  assign chan_a_lines_oe  = oe_q[7:0];
  assign chan_b_lines_oe  = oe_q[15:8];
  assign chan_c_lines_oe  = oe_q[23:16];
  assign chan_d_lines_oe  = oe_q[31:24];
  // Synchronised pins and decoded serial inputs.
  assign lines_sampled    = pins_sync;
  assign ser_rx           = rx_q;
  assign ser_cts_n        = cts_q;
  assign ser_dsr_n        = dsr_q;
  assign carrier_detect_n = dcd_q;
  assign ring_indicator_n = ri_q;
  // Engine data input of the first two channels.
  assign engine_data_in   = din_q;
  // Latched selections and the wake request.
  assign func_active      = func_q;
  assign bb_sync_active   = bbsync_q;
  assign resume_req       = resume_q;
endmodule
`default_nettype wire

// *** verification/quad_mux_sva.sv ***
// Checker holding the pin, wake and setup assertions of the quad pin function mux.
`timescale 1ns/1ps
`default_nettype none
module quad_mux_sva (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  func_sel,
  input wire logic        setup_cmd,
  input wire logic [3:0]  line7_txen_cfg,
  input wire logic        remote_wake_en,
  input wire logic        pull_down_en,
  input wire logic        bus_suspended,
  input wire logic [31:0] ser_tx,
  input wire logic [3:0]  rs485_drive_enable,
  input wire logic [31:0] bb_dir,
  input wire logic [1:0]  engine_clock_out,
  input wire logic [7:0]  engine_gp_dir,
  input wire logic [7:0]  chan_a_lines_in,
  input wire logic [7:0]  chan_a_lines_out,
  input wire logic [7:0]  chan_a_lines_oe,
  input wire logic [7:0]  chan_b_lines_oe,
  input wire logic [7:0]  chan_c_lines_out,
  input wire logic [7:0]  chan_c_lines_oe,
  input wire logic [31:0] lines_sampled,
  input wire logic [1:0]  engine_data_in,
  input wire logic [7:0]  func_active,
  input wire logic        resume_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Edges since reset, saturating; pin and sync checks must not look back into reset.
  logic [1:0] clean;
  always_ff @(posedge clk) begin
    if (srst) begin
      clean <= 2'h0;
    end else if (clean != 2'h3) begin
      clean <= clean + 2'h1;
    end
  end
  // Setup is taken on one edge and reported on the next.
  sequence s_cmd;
    setup_cmd;
  endsequence
  // Channel A ran serial with ring input on line seven in the previous cycle.
  sequence s_ser_a;
    clean != 2'h0 && $past(func_active[1:0]) == pin_mux_pkg::FUNC_SERIAL && !$past(line7_txen_cfg[0]);
  endsequence
  AST_SETUP: assert property (s_cmd |=> func_active == $past(func_sel))
    else $error("function select not taken on setup");
  AST_SERIAL_OE: assert property (s_ser_a |-> chan_a_lines_oe == pin_mux_pkg::SERIAL_OE)
    else $error("serial drive pattern wrong on channel a");
  AST_SERIAL_TX: assert property (s_ser_a |-> chan_a_lines_out[0] == $past(ser_tx[0]))
    else $error("transmit line does not follow transmit data");
  AST_TXEN_C: assert property (clean != 2'h0 && $past(func_active[5:4]) == pin_mux_pkg::FUNC_SERIAL
    && $past(line7_txen_cfg[2]) |-> chan_c_lines_oe[7] && chan_c_lines_out[7] == $past(rs485_drive_enable[2]))
    else $error("transmit enable not driven on channel c");
  AST_BB_DIR: assert property (clean != 2'h0 && $past(func_active[3:2]) == pin_mux_pkg::FUNC_BITBANG
    |-> chan_b_lines_oe == $past(bb_dir[15:8]))
    else $error("bit-bang direction wrong on channel b");
  AST_ENGINE_A: assert property (clean != 2'h0 && $past(func_active[1:0]) == pin_mux_pkg::FUNC_ENGINE
    |-> chan_a_lines_oe == {$past(engine_gp_dir[3:0]), pin_mux_pkg::ENGINE_LOW_OE}
    && chan_a_lines_out[0] == $past(engine_clock_out[0]))
    else $error("engine pin pattern wrong on channel a");
  AST_ENGINE_C: assert property (clean != 2'h0 && $past(func_active[5:4]) == pin_mux_pkg::FUNC_ENGINE
    && !$past(line7_txen_cfg[2]) |-> chan_c_lines_oe == pin_mux_pkg::SERIAL_OE)
    else $error("engine code on channel c not treated as serial");
  AST_SAMPLE: assert property (clean >= 2'h2 |-> lines_sampled[7:0] == $past(chan_a_lines_in, 2))
    else $error("sampled lines lag wrong on channel a");
  AST_DATA_IN: assert property (clean == 2'h3 |-> engine_data_in[0] == $past(chan_a_lines_in[2], 3))
    else $error("engine data input not taken from line two");
  AST_RESUME_ONE: assert property (resume_req |=> !resume_req)
    else $error("resume request longer than one cycle");
  AST_RESUME_WHY: assert property (resume_req |-> $past(remote_wake_en) && $past(bus_suspended))
    else $error("resume request without wake enable and suspend");
  AST_NO_WAKE_PD: assert property ($past(pull_down_en) |-> !resume_req)
    else $error("resume request while pull-down enabled");
endmodule
bind quad_channel_pin_function_mux quad_mux_sva u_sva (
  .clk(clk), .srst(srst), .func_sel(func_sel), .setup_cmd(setup_cmd), .line7_txen_cfg(line7_txen_cfg),
  .remote_wake_en(remote_wake_en), .pull_down_en(pull_down_en), .bus_suspended(bus_suspended),
  .ser_tx(ser_tx), .rs485_drive_enable(rs485_drive_enable), .bb_dir(bb_dir), .engine_clock_out(engine_clock_out),
  .engine_gp_dir(engine_gp_dir), .chan_a_lines_in(chan_a_lines_in), .chan_a_lines_out(chan_a_lines_out),
  .chan_a_lines_oe(chan_a_lines_oe), .chan_b_lines_oe(chan_b_lines_oe), .chan_c_lines_out(chan_c_lines_out),
  .chan_c_lines_oe(chan_c_lines_oe), .lines_sampled(lines_sampled), .engine_data_in(engine_data_in),
  .func_active(func_active), .resume_req(resume_req));
`default_nettype wire

// *** verification/pin_partner.sv ***
// Model of the external transceivers and targets on the 32 channel lines.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic [31:0] dev_out,
  input  wire logic [31:0] dev_oe,
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] ext_en,
  output logic [31:0]      wire_lvl
);
  // Each line rests high through its pull-up when nobody drives it, so a released
  // line never shows a stale value.
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (dev_oe[i]) begin
        wire_lvl[i] = dev_out[i];
      end else if (ext_en[i]) begin
        wire_lvl[i] = ext_val[i];
      end else begin
        wire_lvl[i] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench for the quad pin function mux.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, srst, setup_cmd, remote_wake_en, pull_down_en, bus_suspended, resume_req;
  logic [7:0]  func_sel, engine_gp_out, engine_gp_dir, func_active;
  logic [3:0]  bb_sync_sel, line7_txen_cfg, ser_dtr_n, rs485_drive_enable, bb_sync_active;
  logic [3:0]  ser_rx, ser_cts_n, ser_dsr_n, carrier_detect_n, ring_indicator_n;
  logic [1:0]  engine_clock_out, engine_data_out, engine_select_out, engine_data_in;
  logic [31:0] ser_tx, ser_rts_n, bb_data_out, bb_dir, lines_sampled;
  logic [31:0] out_all, oe_all, wire_lvl, ext_val, ext_en;
  int          failures, cmp_count;

  quad_channel_pin_function_mux u_dut (
    .clk(clk), .srst(srst), .func_sel(func_sel), .setup_cmd(setup_cmd), .bb_sync_sel(bb_sync_sel),
    .line7_txen_cfg(line7_txen_cfg), .remote_wake_en(remote_wake_en), .pull_down_en(pull_down_en),
    .bus_suspended(bus_suspended), .ser_tx(ser_tx), .ser_rts_n(ser_rts_n), .ser_dtr_n(ser_dtr_n),
    .rs485_drive_enable(rs485_drive_enable), .bb_data_out(bb_data_out), .bb_dir(bb_dir),
    .engine_clock_out(engine_clock_out), .engine_data_out(engine_data_out), .engine_select_out(engine_select_out),
    .engine_gp_out(engine_gp_out), .engine_gp_dir(engine_gp_dir),
    .chan_a_lines_in(wire_lvl[7:0]), .chan_b_lines_in(wire_lvl[15:8]),
    .chan_c_lines_in(wire_lvl[23:16]), .chan_d_lines_in(wire_lvl[31:24]),
    .chan_a_lines_out(out_all[7:0]), .chan_b_lines_out(out_all[15:8]),
    .chan_c_lines_out(out_all[23:16]), .chan_d_lines_out(out_all[31:24]),
    .chan_a_lines_oe(oe_all[7:0]), .chan_b_lines_oe(oe_all[15:8]),
    .chan_c_lines_oe(oe_all[23:16]), .chan_d_lines_oe(oe_all[31:24]),
    .lines_sampled(lines_sampled), .ser_rx(ser_rx), .ser_cts_n(ser_cts_n), .ser_dsr_n(ser_dsr_n),
    .carrier_detect_n(carrier_detect_n), .ring_indicator_n(ring_indicator_n), .engine_data_in(engine_data_in),
    .func_active(func_active), .bb_sync_active(bb_sync_active), .resume_req(resume_req));

  pin_partner u_partner (.dev_out(out_all), .dev_oe(oe_all), .ext_val(ext_val), .ext_en(ext_en), .wire_lvl(wire_lvl));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Lets n edges pass and steps clear of the edge so outputs are settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Issues a setup command; pins carry the new function one edge after the taking edge.
  task automatic apply(input logic [7:0] f, input logic [3:0] s);
    @(posedge clk);
    func_sel    <= f;
    bb_sync_sel <= s;
    setup_cmd   <= 1'b1;
    @(posedge clk);
    setup_cmd   <= 1'b0;
    tick(2);
  endtask

  // Counts resume pulses over a fixed window.
  task automatic count_resume(input int n, output int hits);
    hits = 0;
    repeat (n) begin
      tick(1);
      if (resume_req === 1'b1) hits++;
    end
  endtask

  // Reset values seen while reset is held.
  task automatic t_reset;
    chk(oe_all, {4{pin_mux_pkg::RESET_OE}}, "reset oe");
    chk(out_all, {4{pin_mux_pkg::RESET_LINES}}, "reset lines");
    chk({func_active, resume_req, ser_rx}, 13'h000f, "reset status");
    $display("t_reset done");
  endtask

  // All channels serial; line seven of channel c as transmit enable; inputs on channel a.
  task automatic t_serial;
    @(posedge clk);
    ser_tx             <= 32'h00010001;
    ser_rts_n          <= 32'h00000000;
    ser_dtr_n          <= 4'h5;
    rs485_drive_enable <= 4'h4;
    line7_txen_cfg     <= 4'h4;
    ext_en             <= 32'h000000ea;
    ext_val            <= 32'h000000b5;
    apply(8'h00, 4'h0);
    chk(oe_all, 32'h15951515, "serial oe");
    chk(out_all & oe_all, 32'h00910011, "serial drive");
    tick(4);
    chk(lines_sampled[7:0], 8'hb1, "serial pins");
    chk({ser_rx, ser_cts_n, ser_dsr_n, carrier_detect_n, ring_indicator_n}, 20'heefef, "serial inputs");
    $display("t_serial done");
  endtask

  // Bit-bang in both variants must give the same pins.
  task automatic t_bitbang;
    @(posedge clk);
    bb_data_out <= 32'h3c5aa5ff;
    bb_dir      <= 32'h0ff0a55a;
    ext_en      <= 32'h00000000;
    for (int v = 0; v < 2; v++) begin
      apply(8'h55, v ? 4'h5 : 4'ha);
      chk(oe_all, 32'h0ff0a55a, "bitbang oe");
      chk(out_all & oe_all, 32'h0c50a55a, "bitbang drive");
      tick(3);
      chk(lines_sampled, 32'hfc5fffff, "bitbang pins");
      chk({func_active, bb_sync_active}, {8'h55, v ? 4'h5 : 4'ha}, "bitbang status");
    end
    $display("t_bitbang done");
  endtask

  // Engines on a and b, engine code on c, bit-bang on d.
  task automatic t_engine;
    @(posedge clk);
    engine_clock_out  <= 2'b01;
    engine_data_out   <= 2'b10;
    engine_select_out <= 2'b01;
    engine_gp_out     <= 8'h5a;
    engine_gp_dir     <= 8'h3c;
    line7_txen_cfg    <= 4'h0;
    ext_en            <= 32'h00000404;
    ext_val           <= 32'h00000400;
    apply(8'h6a, 4'h0);
    chk(oe_all, 32'h0f153bcb, "engine oe");
    chk(out_all & oe_all, 32'h0c111289, "engine drive");
    tick(4);
    chk({func_active, engine_data_in}, {8'h6a, 2'b10}, "engine inputs");
    $display("t_engine done");
  endtask

  // Ring low in suspend wakes once; pull-down blocks it.
  task automatic t_wake;
    int hits;
    @(posedge clk);
    ext_en         <= 32'h00000000;
    remote_wake_en <= 1'b1;
    bus_suspended  <= 1'b1;
    apply(8'h00, 4'h0);
    @(posedge clk);
    ext_val <= 32'h00000000;
    ext_en  <= 32'h00000080;
    count_resume(8, hits);
    chk(hits, 1, "resume pulses");
    @(posedge clk);
    ext_en       <= 32'h00000000;
    pull_down_en <= 1'b1;
    tick(4);
    @(posedge clk);
    ext_en <= 32'h00000080;
    count_resume(8, hits);
    chk(hits, 0, "resume with pull-down");
    $display("t_wake done");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("Error %0t: run did not finish", $time);
    end_sim;
  end

  // Main sequence.
  initial begin
    {srst, setup_cmd, remote_wake_en, pull_down_en, bus_suspended} = 5'b10000;
    {func_sel, bb_sync_sel, line7_txen_cfg, ser_dtr_n, rs485_drive_enable} = '0;
    {ser_tx, ser_rts_n, bb_data_out, bb_dir, ext_val, ext_en} = '0;
    {engine_clock_out, engine_data_out, engine_select_out, engine_gp_out, engine_gp_dir} = '0;
    failures  = 0;
    cmp_count = 0;
    tick(5);
    t_reset;
    @(posedge clk);
    srst <= 1'b0;
    t_serial;
    t_bitbang;
    t_engine;
    t_wake;
    end_sim;
  end
endmodule
`default_nettype wire
